// ---- include/eio_pkg.sv ----
// Shared constants and types for the extended I/O bus master
package eio_pkg;

  // Bus clock divisors selected by the power-on strap
  localparam logic [2:0] EIO_DIV_SLOW = 3'h4;
  localparam logic [2:0] EIO_DIV_FAST = 3'h3;
  // Bus clock high time in host clocks, both divisors
  localparam logic [2:0] EIO_CLK_HIGH = 3'h2;

  // Supported bus clock rates, kHz
  localparam int EIO_BCLK_KHZ_LO = 6250;
  localparam int EIO_BCLK_KHZ_MID = 7500;
  localparam int EIO_BCLK_KHZ_HI = 8333;

  // Cycle phase lengths in bus clocks
  localparam logic [2:0] EIO_CMD_CLKS = 3'h4;
  localparam logic [2:0] EIO_ZWS_CMD_CLKS = 3'h2;

  // Pin values after reset and during DMA
  localparam logic [1:0] EIO_ADDR_HI_RST = 2'h3;
  localparam logic [7:0] EIO_ADDR_BYTE_RST = 8'h00;
  localparam logic [7:0] EIO_DATA_BYTE_RST = 8'h00;
  localparam logic [15:0] EIO_RDATA_RST = 16'h0000;

  typedef enum logic [1:0] {
    EIO_CMD_IO_RD,
    EIO_CMD_IO_WR,
    EIO_CMD_MEM_RD,
    EIO_CMD_MEM_WR
  } eio_cmd_e;

  typedef enum logic [1:0] {
    EIO_IDLE,
    EIO_ADDR,
    EIO_STROBE,
    EIO_RECOV
  } eio_state_e;

endpackage : eio_pkg

// ---- rtl/eio_clk_div.sv ----
// Bus clock divider with power-on divisor strap
`timescale 1ns/1ps
module eio_clk_div
  import eio_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Power and host reset
  input wire logic i_power_good,
  input wire logic i_host_bus_reset_n,
  // Bus clock pin
  input wire logic i_bus_clock_in,
  output logic o_bus_clock_out,
  output logic o_bus_clock_oe,
  output logic o_bus_clock_pullup_en,
  // Divider state
  output logic o_tick,
  output logic [2:0] o_div
);

  logic pg_q;
  logic [2:0] div;
  logic [2:0] cnt;
  logic clk_out;
  logic pullup_en;

  wire pg_rise = i_power_good & ~pg_q;
  wire cnt_wrap = (cnt == div - 3'h1);
  wire [2:0] next_cnt = (~pg_q | cnt_wrap) ? 3'h0 : cnt + 3'h1;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pg_q <= 1'b0;
      div <= EIO_DIV_SLOW;
      cnt <= 3'h0;
      clk_out <= 1'b0;
      pullup_en <= 1'b1;
    end else if (i_ce) begin
      pg_q <= i_power_good;
      if (pg_rise) begin
        div <= i_bus_clock_in ? EIO_DIV_SLOW : EIO_DIV_FAST;
      end
      cnt <= next_cnt;
      clk_out <= i_power_good & (next_cnt < EIO_CLK_HIGH);
      if (pg_q && i_host_bus_reset_n) begin
        pullup_en <= 1'b0;
      end
    end
  end

  assign o_bus_clock_out = clk_out;
  assign o_bus_clock_oe = pg_q;
  assign o_bus_clock_pullup_en = pullup_en;
  assign o_tick = pg_q & cnt_wrap & i_ce;
  assign o_div = div;

endmodule : eio_clk_div

// ---- rtl/eio_pin_drive.sv ----
// Registered address, data and direction pin drivers
`timescale 1ns/1ps
module eio_pin_drive
  import eio_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_host_bus_reset_n,
  // Current cycle
  input wire logic i_active,
  input wire logic i_data_phase,
  input wire logic i_dma,
  input wire logic i_mem,
  input wire logic i_write,
  input wire logic [17:0] i_addr,
  input wire logic [15:0] i_wdata,
  // Pins
  output logic [7:0] o_addr_lo,
  output logic [1:0] o_addr_hi,
  output logic [7:0] o_disk_data_hi,
  output logic o_disk_data_hi_oe,
  output logic [7:0] o_data_lo,
  output logic o_data_lo_oe,
  output logic o_xcvr_direction
);

  wire dma_data = i_active & i_dma & i_data_phase;
  wire [7:0] next_addr_lo = i_dma ? EIO_ADDR_BYTE_RST : i_addr[7:0];
  wire [7:0] next_addr_mid = i_dma ? EIO_ADDR_BYTE_RST : i_addr[15:8];
  wire [1:0] next_addr_hi =
    (i_active & i_mem & ~i_dma) ? i_addr[17:16] : EIO_ADDR_HI_RST;
  wire [7:0] next_dd_hi = dma_data ? i_wdata[15:8] : next_addr_mid;
  wire next_dd_hi_oe = i_host_bus_reset_n & ~(dma_data & ~i_write);
  wire next_data_lo_oe = i_host_bus_reset_n & i_active & i_write;
  wire next_dir = ~(i_active & i_data_phase & ~i_write);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_addr_lo <= EIO_ADDR_BYTE_RST;
      o_addr_hi <= EIO_ADDR_HI_RST;
      o_disk_data_hi <= EIO_ADDR_BYTE_RST;
      o_disk_data_hi_oe <= 1'b0;
      o_data_lo <= EIO_DATA_BYTE_RST;
      o_data_lo_oe <= 1'b0;
      o_xcvr_direction <= 1'b1;
    end else if (i_ce) begin
      if (i_active) begin
        o_addr_lo <= next_addr_lo;
        o_disk_data_hi <= next_dd_hi;
        o_data_lo <= i_wdata[7:0];
      end
      o_addr_hi <= next_addr_hi;
      o_disk_data_hi_oe <= next_dd_hi_oe;
      o_data_lo_oe <= next_data_lo_oe;
      o_xcvr_direction <= next_dir;
    end
  end

endmodule : eio_pin_drive

// ---- rtl/eio_bus_master.sv ----
// Extended I/O bus master: cycle sequencer, strobes and pin control
`timescale 1ns/1ps
module eio_bus_master
  import eio_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Power and host reset
  input wire logic i_power_good,
  input wire logic i_host_bus_reset_n,
  // Bus clock pin
  input wire logic i_bus_clock_in,
  output logic o_bus_clock_out,
  output logic o_bus_clock_oe,
  output logic o_bus_clock_pullup_en,
  // Slave handshakes
  input wire logic i_channel_ready_in,
  input wire logic i_no_wait_n,
  // Command strobes
  output logic o_io_read_strobe_n,
  output logic o_io_write_strobe_n,
  output logic o_mem_read_strobe_n,
  output logic o_mem_write_strobe_n,
  // Address pins
  output logic [7:0] o_system_addr_lo,
  output logic [1:0] o_system_addr_hi,
  // Shared disk data pins, upper address or upper data
  input wire logic [7:0] i_disk_data_hi,
  output logic [7:0] o_disk_data_hi,
  output logic o_disk_data_hi_oe,
  // Low data byte
  input wire logic [7:0] i_system_data_bus,
  output logic [7:0] o_system_data_bus,
  output logic o_system_data_bus_oe,
  // Transceiver direction
  output logic o_xcvr_direction,
  // Request port
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire eio_cmd_e i_req_cmd,
  input wire logic i_req_dma,
  input wire logic [17:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  // Answer port
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_rdata,
  // Divider status
  output logic [2:0] o_clk_div
);

  //////////////////////////////////////////////////////////////////////////
  // Bus clock generation

  logic tick;

  eio_clk_div u_clk_div (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_power_good(i_power_good),
    .i_host_bus_reset_n(i_host_bus_reset_n),
    .i_bus_clock_in(i_bus_clock_in),
    .o_bus_clock_out(o_bus_clock_out),
    .o_bus_clock_oe(o_bus_clock_oe),
    .o_bus_clock_pullup_en(o_bus_clock_pullup_en),
    .o_tick(tick),
    .o_div(o_clk_div)
  );

  //////////////////////////////////////////////////////////////////////////
  // Latched request

  eio_state_e state;
  eio_state_e next_state;
  eio_cmd_e cmd;
  logic dma;
  logic [17:0] addr;
  logic [15:0] wdata;
  logic [2:0] clk_cnt;
  logic addr_new;
  logic [15:0] rdata;
  logic rsp_valid;
  logic io_rd_n;
  logic io_wr_n;
  logic mem_rd_n;
  logic mem_wr_n;

  // Command decode
  wire cmd_io_rd = (cmd == EIO_CMD_IO_RD);
  wire cmd_io_wr = (cmd == EIO_CMD_IO_WR);
  wire cmd_mem_rd = (cmd == EIO_CMD_MEM_RD);
  wire cmd_mem_wr = (cmd == EIO_CMD_MEM_WR);

  // Request decode
  wire idle = (state == EIO_IDLE);
  wire take = idle & i_req_valid & i_host_bus_reset_n & i_ce;
  wire is_mem = cmd_mem_rd | cmd_mem_wr;
  wire is_write = cmd_io_wr | cmd_mem_wr;
  wire active = ~idle;
  // Pins turn with the strobe, not one clock after it
  wire data_phase = (next_state == EIO_STROBE) & i_host_bus_reset_n;

  assign o_req_ready = idle & i_host_bus_reset_n & i_ce;

  //////////////////////////////////////////////////////////////////////////
  // Cycle length decode

  // Strobe clocks completed including the one ending now
  wire [2:0] clk_done = clk_cnt + 3'h1;
  wire full_len = (clk_done >= EIO_CMD_CLKS);
  wire zws_len = ~i_no_wait_n & (clk_done >= EIO_ZWS_CMD_CLKS);
  // Wait states while the slave holds channel ready low
  wire slave_ready = i_channel_ready_in;
  wire strobe_end = tick & slave_ready & (full_len | zws_len);

  // First strobe waits until the address pins have settled
  wire addr_done = tick & ~addr_new;

  //////////////////////////////////////////////////////////////////////////
  // Cycle sequencer

  always_comb begin
    next_state = state;
    case (state)
      EIO_IDLE: begin
        if (take) begin
          next_state = EIO_ADDR;
        end
      end
      EIO_ADDR: begin
        if (addr_done) begin
          next_state = EIO_STROBE;
        end
      end
      EIO_STROBE: begin
        if (strobe_end) begin
          next_state = EIO_RECOV;
        end
      end
      EIO_RECOV: begin
        if (tick) begin
          next_state = EIO_IDLE;
        end
      end
      default: begin
        next_state = EIO_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= EIO_IDLE;
    end else if (i_ce) begin
      if (!i_host_bus_reset_n) begin
        state <= EIO_IDLE;
      end else begin
        state <= next_state;
      end
    end
  end

  // Strobe clock counter, stops counting at EIO_CMD_CLKS - 1
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clk_cnt <= 3'h0;
    end else if (i_ce) begin
      if (state != EIO_STROBE) begin
        clk_cnt <= 3'h0;
      end else if (tick && !full_len) begin
        clk_cnt <= clk_done;
      end
    end
  end

  // Request capture
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cmd <= EIO_CMD_IO_RD;
    end else if (take) begin
      cmd <= i_req_cmd;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dma <= 1'b0;
    end else if (take) begin
      dma <= i_req_dma;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      addr <= 18'h00000;
    end else if (take) begin
      addr <= i_req_addr;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wdata <= 16'h0000;
    end else if (take) begin
      wdata <= i_req_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address setup

  // Set for the one host clock after a request is taken
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      addr_new <= 1'b0;
    end else if (i_ce) begin
      addr_new <= take;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command strobes

  // Strobe asserts for the whole strobe phase of its command
  wire strobe_on = (next_state == EIO_STROBE) & i_host_bus_reset_n;
  wire next_io_rd_n = ~(strobe_on & cmd_io_rd);
  wire next_io_wr_n = ~(strobe_on & cmd_io_wr);
  wire next_mem_rd_n = ~(strobe_on & cmd_mem_rd);
  wire next_mem_wr_n = ~(strobe_on & cmd_mem_wr);

  // One short register per strobe
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      io_rd_n <= 1'b1;
    end else if (i_ce) begin
      io_rd_n <= next_io_rd_n;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      io_wr_n <= 1'b1;
    end else if (i_ce) begin
      io_wr_n <= next_io_wr_n;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mem_rd_n <= 1'b1;
    end else if (i_ce) begin
      mem_rd_n <= next_mem_rd_n;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mem_wr_n <= 1'b1;
    end else if (i_ce) begin
      mem_wr_n <= next_mem_wr_n;
    end
  end

  assign o_io_read_strobe_n = io_rd_n;
  assign o_io_write_strobe_n = io_wr_n;
  assign o_mem_read_strobe_n = mem_rd_n;
  assign o_mem_write_strobe_n = mem_wr_n;

  //////////////////////////////////////////////////////////////////////////
  // Read data capture and answer

  // Upper byte is meaningful only for DMA reads
  wire [7:0] rd_hi = dma ? i_disk_data_hi : EIO_DATA_BYTE_RST;
  wire rd_done = (state == EIO_STROBE) & strobe_end & ~is_write;
  wire cycle_done = (state == EIO_RECOV) & tick;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata <= EIO_RDATA_RST;
    end else if (i_ce && rd_done) begin
      rdata <= {rd_hi, i_system_data_bus};
    end
  end

  // Answer pulse for reads and writes alike
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rsp_valid <= 1'b0;
    end else if (i_ce) begin
      rsp_valid <= cycle_done & i_host_bus_reset_n;
    end
  end

  assign o_rsp_valid = rsp_valid;
  assign o_rsp_rdata = rdata;

  //////////////////////////////////////////////////////////////////////////
  // Address, data and direction pins

  eio_pin_drive u_pin_drive (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_host_bus_reset_n(i_host_bus_reset_n),
    .i_active(active),
    .i_data_phase(data_phase),
    .i_dma(dma),
    .i_mem(is_mem),
    .i_write(is_write),
    .i_addr(addr),
    .i_wdata(wdata),
    .o_addr_lo(o_system_addr_lo),
    .o_addr_hi(o_system_addr_hi),
    .o_disk_data_hi(o_disk_data_hi),
    .o_disk_data_hi_oe(o_disk_data_hi_oe),
    .o_data_lo(o_system_data_bus),
    .o_data_lo_oe(o_system_data_bus_oe),
    .o_xcvr_direction(o_xcvr_direction)
  );

endmodule : eio_bus_master

// ---- verif/eio_chk.sv ----
// Protocol checker for the extended bus master
`timescale 1ns/1ps
module eio_chk
  import eio_pkg::*;
(
  // Clock, reset, power
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_power_good,
  input wire logic i_host_bus_reset_n,
  // Bus clock
  input wire logic i_bus_clock_in,
  input wire logic o_bus_clock_out,
  input wire logic o_bus_clock_oe,
  input wire logic [2:0] o_clk_div,
  // Handshakes and strobes
  input wire logic i_channel_ready_in,
  input wire logic i_no_wait_n,
  input wire logic o_io_read_strobe_n,
  input wire logic o_io_write_strobe_n,
  input wire logic o_mem_read_strobe_n,
  input wire logic o_mem_write_strobe_n,
  // Pins
  input wire logic [1:0] o_system_addr_hi,
  input wire logic o_system_data_bus_oe,
  input wire logic o_xcvr_direction
);
  wire cmd_n = &{o_io_read_strobe_n, o_io_write_strobe_n,
                 o_mem_read_strobe_n, o_mem_write_strobe_n};
  wire rd = !(o_io_read_strobe_n && o_mem_read_strobe_n);
  wire wr = !(o_io_write_strobe_n && o_mem_write_strobe_n);
  wire io = !(o_io_read_strobe_n && o_io_write_strobe_n);
  logic [7:0] low_cnt;
  logic zws;
  logic wt;
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      low_cnt <= 8'h00;
      zws <= 1'b0;
      wt <= 1'b0;
    end else begin
      low_cnt <= cmd_n ? 8'h00 : low_cnt + 8'h01;
      zws <= !cmd_n && (zws || !i_no_wait_n);
      wt <= !cmd_n && (wt || !i_channel_ready_in);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  clk_float_a: assert property (
    !i_power_good |=> !o_bus_clock_oe) else $error("clock driven");
  strap_sel_a: assert property (
    $rose(o_bus_clock_oe) |-> o_clk_div == ($past(i_bus_clock_in) ?
    EIO_DIV_SLOW : EIO_DIV_FAST)) else $error("wrong divisor");
  bclk_div4_a: assert property (
    $rose(o_bus_clock_out) && o_clk_div == EIO_DIV_SLOW |->
    o_bus_clock_out[*2] ##1 !o_bus_clock_out[*2] ##1 o_bus_clock_out)
    else $error("bus clock period wrong");
  wait_hold_a: assert property (
    !cmd_n && !i_channel_ready_in |=> !cmd_n) else $error("wait lost");
  strobe_len_a: assert property (
    $rose(cmd_n) && !wt |-> low_cnt == (zws ? 8'h02 : 8'h04) * o_clk_div)
    else $error("strobe length wrong");
  read_pins_a: assert property (
    rd |-> !o_system_data_bus_oe && !o_xcvr_direction)
    else $error("read pins wrong");
  write_pins_a: assert property (
    wr |-> o_system_data_bus_oe && o_xcvr_direction)
    else $error("write pins wrong");
  io_addr_a: assert property (
    io |-> o_system_addr_hi == EIO_ADDR_HI_RST) else $error("upper addr");
  host_rst_a: assert property (
    !i_host_bus_reset_n |=> cmd_n && !o_system_data_bus_oe)
    else $error("host reset pins");
  cover property ($rose(cmd_n) && zws);
  cover property ($rose(cmd_n) && wt);
  cover property ($rose(o_bus_clock_oe) && o_clk_div == EIO_DIV_FAST);
endmodule : eio_chk
bind eio_bus_master eio_chk u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .i_power_good(i_power_good), .i_host_bus_reset_n(i_host_bus_reset_n),
  .i_bus_clock_in(i_bus_clock_in), .o_bus_clock_out(o_bus_clock_out),
  .o_bus_clock_oe(o_bus_clock_oe), .o_clk_div(o_clk_div),
  .i_channel_ready_in(i_channel_ready_in), .i_no_wait_n(i_no_wait_n),
  .o_io_read_strobe_n(o_io_read_strobe_n),
  .o_io_write_strobe_n(o_io_write_strobe_n),
  .o_mem_read_strobe_n(o_mem_read_strobe_n),
  .o_mem_write_strobe_n(o_mem_write_strobe_n),
  .o_system_addr_hi(o_system_addr_hi),
  .o_system_data_bus_oe(o_system_data_bus_oe),
  .o_xcvr_direction(o_xcvr_direction));

// ---- verif/eio_slave.sv ----
// Behavioural slave on the extended bus
`timescale 1ns/1ps
module eio_slave (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Behaviour select
  input wire logic [2:0] i_waits,
  input wire logic i_zws,
  // Bus side
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [17:0] i_addr,
  input wire logic [7:0] i_sd,
  output logic o_ready,
  output logic o_no_wait_n,
  output logic [7:0] o_sd,
  output logic [7:0] o_dd,
  // Captured cycle
  output logic [17:0] o_addr,
  output logic [7:0] o_wr
);
  logic cmd_q;
  logic [5:0] wcnt;
  logic [17:0] pre;
  wire cmd_n = i_rd_n & i_wr_n;
  wire first = cmd_q && !cmd_n;
  assign o_ready = (wcnt == 6'h00);
  assign o_no_wait_n = !(i_zws && !cmd_n);
  assign o_sd = !i_rd_n ? (pre[7:0] ^ 8'h5a) : 8'hff;
  assign o_dd = !i_rd_n ? 8'hc3 : 8'h3c;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cmd_q <= 1'b1;
      wcnt <= 6'h00;
      pre <= 18'h00000;
      o_addr <= 18'h00000;
      o_wr <= 8'h00;
    end else begin
      cmd_q <= cmd_n;
      wcnt <= first ? {i_waits, 3'h0} : wcnt - 6'(wcnt != 6'h00);
      if (cmd_n) pre <= i_addr;
      if (first) o_addr <= pre;
      if (!i_wr_n) o_wr <= i_sd;
    end
  end
endmodule : eio_slave

// ---- verif/eio_bus_master_tb.sv ----
// Self-checking bench for the extended bus master
`timescale 1ns/1ps
module eio_bus_master_tb;
  import eio_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, pg = 1'b0, hr_n = 1'b0, st_lo = 1'b0;
  logic vld = 1'b0, dma = 1'b0, zws = 1'b0;
  eio_cmd_e cmd = EIO_CMD_IO_RD;
  logic [17:0] adr = 18'h00000;
  logic [15:0] wd = 16'h0000;
  logic [2:0] wts = 3'h0;
  logic bco, bcoe, pu, rdy, nw_n, ior_n, iow_n, mr_n, mw_n;
  logic sd_oe, dd_oe, dir, qrdy, rv;
  logic [7:0] sa_lo, dd_o, sd_o, s_sd, s_dd, s_wr;
  logic [1:0] sa_hi;
  logic [15:0] rd;
  logic [2:0] div;
  logic [17:0] s_adr;
  int error_cnt = 0, compares = 0;
  wire bci = bcoe ? bco : (!st_lo && pu);
  wire [7:0] dd = dd_oe ? dd_o : s_dd;
  wire [7:0] sd = sd_oe ? sd_o : s_sd;
  always #5 clk = ~clk;
  eio_bus_master dut (.i_sys_clk(clk), .i_rstn(rstn), .i_ce(1'b1),
    .i_power_good(pg), .i_host_bus_reset_n(hr_n), .i_bus_clock_in(bci),
    .o_bus_clock_out(bco), .o_bus_clock_oe(bcoe),
    .o_bus_clock_pullup_en(pu), .i_channel_ready_in(rdy),
    .i_no_wait_n(nw_n), .o_io_read_strobe_n(ior_n),
    .o_io_write_strobe_n(iow_n), .o_mem_read_strobe_n(mr_n),
    .o_mem_write_strobe_n(mw_n), .o_system_addr_lo(sa_lo),
    .o_system_addr_hi(sa_hi), .i_disk_data_hi(dd), .o_disk_data_hi(dd_o),
    .o_disk_data_hi_oe(dd_oe), .i_system_data_bus(sd),
    .o_system_data_bus(sd_o), .o_system_data_bus_oe(sd_oe),
    .o_xcvr_direction(dir), .i_req_valid(vld), .o_req_ready(qrdy),
    .i_req_cmd(cmd), .i_req_dma(dma), .i_req_addr(adr), .i_req_wdata(wd),
    .o_rsp_valid(rv), .o_rsp_rdata(rd), .o_clk_div(div));
  eio_slave sl (.i_clk(clk), .i_rstn(rstn), .i_waits(wts), .i_zws(zws),
    .i_rd_n(ior_n & mr_n), .i_wr_n(iow_n & mw_n),
    .i_addr({sa_hi, dd, sa_lo}), .i_sd(sd), .o_ready(rdy),
    .o_no_wait_n(nw_n), .o_sd(s_sd), .o_dd(s_dd), .o_addr(s_adr),
    .o_wr(s_wr));
  //////////////////////////////////////////////////////////////////////////
  task tk(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : tk
  task cmp(input logic [17:0] g, input logic [17:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task go(input eio_cmd_e c, input logic d, input logic [17:0] a,
          input logic [15:0] w);
    int n;
    n = 0;
    vld = 1'b1;
    cmd = c;
    dma = d;
    adr = a;
    wd = w;
    while (qrdy !== 1'b1 && n < 400) begin
      tk(1);
      n++;
    end
    tk(1);
    vld = 1'b0;
    while (rv !== 1'b1 && n < 400) begin
      tk(1);
      n++;
    end
    if (n >= 400) begin
      error_cnt++;
      give_verdict;
    end
  endtask : go
  task give_verdict;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    tk(8);
    rstn = 1'b1;
    tk(2);
    cmp({bcoe, pu, sd_oe, dir, sa_hi}, 6'h17);
    cmp({ior_n, iow_n, mr_n, mw_n}, 4'hf);
    pg = 1'b1;
    tk(3);
    cmp(div, EIO_DIV_SLOW);
    hr_n = 1'b1;
    tk(3);
    cmp(pu, 1'b0);
  endtask : t_reset
  task t_io;
    go(EIO_CMD_IO_RD, 1'b0, 18'h0a1b2, 16'h0000);
    cmp(rd, 16'h00e8);
    cmp(s_adr, 18'h3a1b2);
    wts = 3'h3;
    go(EIO_CMD_IO_WR, 1'b0, 18'h00077, 16'h12a5);
    wts = 3'h0;
    cmp(s_wr, 8'ha5);
    cmp(s_adr, 18'h30077);
  endtask : t_io
  task t_mem;
    zws = 1'b1;
    go(EIO_CMD_MEM_RD, 1'b0, 18'h2f00d, 16'h0000);
    cmp(s_adr, 18'h2f00d);
    cmp(rd, 16'h0057);
    go(EIO_CMD_MEM_WR, 1'b0, 18'h10040, 16'hff3c);
    zws = 1'b0;
    cmp(s_wr, 8'h3c);
    cmp(s_adr, 18'h10040);
  endtask : t_mem
  task t_dma;
    wts = 3'h2;
    go(EIO_CMD_IO_RD, 1'b1, 18'h15555, 16'h0000);
    wts = 3'h0;
    cmp(s_adr, 18'h30000);
    cmp(rd, 16'hc35a);
  endtask : t_dma
  task t_strap;
    int n;
    n = 0;
    rstn = 1'b0;
    pg = 1'b0;
    st_lo = 1'b1;
    tk(8);
    rstn = 1'b1;
    tk(1);
    pg = 1'b1;
    tk(4);
    cmp(div, EIO_DIV_FAST);
    for (int i = 0; i < 12; i++) begin
      tk(1);
      n += int'(bco === 1'b1);
    end
    cmp(18'(n), 18'h00008);
  endtask : t_strap
  initial begin
    t_reset;
    t_io;
    t_mem;
    t_dma;
    t_strap;
    give_verdict;
  end
endmodule : eio_bus_master_tb
